// *** rtl/bto_pkg.sv ***
// Constants and types for the bit-invert / overflow-branch / skip executor
package bto_pkg;
  localparam logic [3:0] BIT_INVERT_PREFIX = 4'h7;
  localparam logic [7:0] BRANCH_OV_PREFIX = 8'hE4;
  localparam logic [3:0] SKIP_CLEAR_PREFIX = 4'hB;
  localparam logic [3:0] SKIP_SET_PREFIX = 4'hA;
  localparam logic [3:0] TWO_WORD_PREFIX = 4'hF;
  localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [20:0] PC_RESET = 21'h00000;
  localparam logic [20:0] PC_STEP = 21'h00002;
  localparam logic [1:0] PHASE_RESET = 2'h0;
  typedef enum logic [1:0] {
    BTO_Q1 = 2'b00,
    BTO_Q2 = 2'b01,
    BTO_Q3 = 2'b10,
    BTO_Q4 = 2'b11
  } bto_phase_t;
endpackage : bto_pkg

// *** rtl/bto_addr_gen.sv ***
// Data-memory address selection for bit-oriented instructions
`timescale 1ns/10ps
`default_nettype none
module bto_addr_gen (
  input wire logic [7:0] file_addr,
  input wire logic bank_flag,
  input wire logic ext_enable,
  input wire logic [3:0] bank_select_register,
  input wire logic [11:0] index_base,
  output logic [11:0] data_addr
);
  import bto_pkg::*;
  // Indexed mode only below the access split, as the literal range is small
  always_comb begin
    if (bank_flag) begin
      data_addr = {bank_select_register, file_addr};
    end else if (ext_enable && file_addr <= INDEXED_LIMIT) begin
      data_addr = index_base + {4'h0, file_addr};
    end else if (file_addr < ACCESS_SPLIT) begin
      data_addr = {4'h0, file_addr};
    end else begin
      data_addr = {ACCESS_HIGH_BANK, file_addr};
    end
  end
endmodule : bto_addr_gen
`default_nettype wire

// *** rtl/bto_exec.sv ***
// Four-phase executor for bit-invert, overflow branch and bit-test skips
`timescale 1ns/10ps
`default_nettype none
module bto_exec (
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] instr_word,
  input wire logic [15:0] next_word,
  input wire logic overflow_flag,
  input wire logic ext_enable,
  input wire logic [3:0] bank_select_register,
  input wire logic [11:0] index_base,
  input wire logic [7:0] mem_rdata,
  output logic [11:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic [20:0] pc,
  output logic [1:0] phase,
  output logic nop_cycle
);
  import bto_pkg::*;

  bto_phase_t q;
  bto_phase_t next_q;
  logic [20:0] next_pc;
  logic [1:0] nop_left;
  logic [1:0] next_nop_left;
  logic [7:0] next_mem_wdata;
  logic next_mem_we;
  logic [11:0] next_mem_addr;
  logic [11:0] addr_comb;
  logic is_invert;
  logic is_bov;
  logic is_skip_clear;
  logic is_skip_set;
  logic bit_val;
  logic do_skip;
  logic [20:0] branch_ofs;
  // Set only for the bubble after a taken branch, which keeps the PC
  logic branch_bubble;
  logic next_branch_bubble;
  logic next_nop_cycle;

  bto_addr_gen u_addr (
    .file_addr(instr_word[7:0]),
    .bank_flag(instr_word[8]),
    .ext_enable(ext_enable),
    .bank_select_register(bank_select_register),
    .index_base(index_base),
    .data_addr(addr_comb)
  );

  // Decode in the current instruction word
  assign is_invert = instr_word[15:12] == BIT_INVERT_PREFIX;
  assign is_bov = instr_word[15:8] == BRANCH_OV_PREFIX;
  assign is_skip_clear = instr_word[15:12] == SKIP_CLEAR_PREFIX;
  assign is_skip_set = instr_word[15:12] == SKIP_SET_PREFIX;
  assign bit_val = mem_rdata[instr_word[11:9]];
  assign do_skip = (is_skip_clear && !bit_val)
      || (is_skip_set && bit_val);
  // Signed offset doubled, sign-extended to PC width
  assign branch_ofs = {{12{instr_word[7]}}, instr_word[7:0], 1'b0};

  // Phase, PC and memory-write sequencing
  always_comb begin
    next_q = bto_phase_t'(q + 2'h1);
    next_pc = pc;
    next_nop_left = nop_left;
    next_mem_we = 1'b0;
    next_mem_wdata = mem_wdata;
    next_mem_addr = mem_addr;
    next_branch_bubble = branch_bubble;
    unique case (q)
      BTO_Q1: begin
        // PC already points past this word once fetched
        if (nop_left == 2'h0) begin
          next_pc = pc + PC_STEP;
          next_mem_addr = addr_comb;
        end
      end
      BTO_Q2: begin
      end
      BTO_Q3: begin
        if (nop_left == 2'h0 && is_invert) begin
          next_mem_wdata = mem_rdata ^ (8'h01 << instr_word[11:9]);
          next_mem_we = 1'b1;
        end
      end
      BTO_Q4: begin
        if (nop_left != 2'h0) begin
          next_nop_left = nop_left - 2'h1;
          next_branch_bubble = 1'b0;
          // A discarded word advances the PC; the branch bubble must not,
          // or the target would land one word too far
          if (!branch_bubble) begin
            next_pc = pc + PC_STEP;
          end
        end else if (is_bov && overflow_flag) begin
          next_pc = pc + branch_ofs;
          next_nop_left = 2'h1;
          next_branch_bubble = 1'b1;
        end else if (do_skip) begin
          // Two-word targets cost an extra discarded cycle
          next_nop_left = (next_word[15:12] == TWO_WORD_PREFIX)
              ? 2'h2 : 2'h1;
        end
      end
    endcase
    // Flag spans the whole slot, so a new slot follows the fresh count
    next_nop_cycle = (next_q == BTO_Q1) ? (next_nop_left != 2'h0)
        : (nop_left != 2'h0);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= BTO_Q1;
      pc <= PC_RESET;
      nop_left <= 2'h0;
      mem_we <= 1'b0;
      mem_wdata <= 8'h00;
      mem_addr <= 12'h000;
      phase <= PHASE_RESET;
      nop_cycle <= 1'b0;
      branch_bubble <= 1'b0;
    end else begin
      q <= next_q;
      pc <= next_pc;
      nop_left <= next_nop_left;
      mem_we <= next_mem_we;
      mem_wdata <= next_mem_wdata;
      mem_addr <= next_mem_addr;
      phase <= next_q;
      nop_cycle <= next_nop_cycle;
      branch_bubble <= next_branch_bubble;
    end
  end

  // Checks watch registered outputs one edge after each decision
  a_invert_writes: assert property (@(posedge clock) disable iff (rst)
    (q == BTO_Q3 && nop_left == 2'h0 && is_invert) |=>
    mem_we && mem_wdata == ($past(mem_rdata)
    ^ (8'h01 << $past(instr_word[11:9]))))
    else $error("bit invert wrong");
  // Write strobe is one cycle, so memory sees exactly one store
  a_write_pulse: assert property (@(posedge clock) disable iff (rst)
    mem_we |=> !mem_we)
    else $error("write pulse stretched");
  // Address selection, seen the edge after decode
  a_bank_select: assert property (@(posedge clock) disable iff (rst)
    (q == BTO_Q1 && nop_left == 2'h0 && instr_word[8]) |=>
    mem_addr == {$past(bank_select_register), $past(instr_word[7:0])})
    else $error("bank select address wrong");
  a_access_bank: assert property (@(posedge clock) disable iff (rst)
    (q == BTO_Q1 && nop_left == 2'h0 && !instr_word[8]
    && (!ext_enable || instr_word[7:0] > INDEXED_LIMIT)) |=>
    mem_addr[7:0] == $past(instr_word[7:0]) && mem_addr[11:8]
    == (($past(instr_word[7:0]) < ACCESS_SPLIT) ? 4'h0 : ACCESS_HIGH_BANK))
    else $error("access bank address wrong");
  a_indexed_mode: assert property (@(posedge clock) disable iff (rst)
    (q == BTO_Q1 && nop_left == 2'h0 && !instr_word[8] && ext_enable
    && instr_word[7:0] <= INDEXED_LIMIT) |=>
    mem_addr == $past(index_base) + {4'h0, $past(instr_word[7:0])})
    else $error("indexed address wrong");
  // Branch checks: the PC is already one word on when Q4 adds the offset
  a_pc_advance: assert property (@(posedge clock) disable iff (rst)
    (q == BTO_Q1 && nop_left == 2'h0) |=> pc == $past(pc) + PC_STEP)
    else $error("pc not advanced at decode");
  a_bov_untaken: assert property (@(posedge clock) disable iff (rst)
    (q == BTO_Q4 && nop_left == 2'h0 && is_bov && !overflow_flag) |=>
    pc == $past(pc) && nop_left == 2'h0)
    else $error("untaken branch moved");
  a_bov_target: assert property (@(posedge clock) disable iff (rst)
    (q == BTO_Q4 && nop_left == 2'h0 && is_bov && overflow_flag) |=>
    pc == $past(pc) + $past(branch_ofs))
    else $error("branch target wrong");
  a_bov_two_cycle: assert property (@(posedge clock) disable iff (rst)
    (q == BTO_Q4 && nop_left == 2'h0 && is_bov && overflow_flag) |=>
    nop_cycle [*4] ##1 !nop_cycle)
    else $error("taken branch not two cycles");
  // The branch bubble must leave the new target alone
  a_bov_nop_hold: assert property (@(posedge clock) disable iff (rst)
    (q == BTO_Q4 && nop_left == 2'h0 && is_bov && overflow_flag) |=>
    ##4 pc == $past(pc, 4))
    else $error("branch bubble moved pc");
  // Skip checks on the bit read back in Q4
  a_skip_clear: assert property (@(posedge clock) disable iff (rst)
    (q == BTO_Q4 && nop_left == 2'h0 && is_skip_clear && !bit_val) |=>
    nop_cycle)
    else $error("skip not taken");
  a_skip_set_bit: assert property (@(posedge clock) disable iff (rst)
    (q == BTO_Q4 && nop_left == 2'h0 && is_skip_clear && bit_val) |=>
    !nop_cycle)
    else $error("skip wrongly taken");
  a_skip_if_set: assert property (@(posedge clock) disable iff (rst)
    (q == BTO_Q4 && nop_left == 2'h0 && is_skip_set && bit_val) |=>
    nop_cycle)
    else $error("skip if set not taken");
  a_skip_one_word: assert property (@(posedge clock) disable iff (rst)
    (q == BTO_Q4 && nop_left == 2'h0 && do_skip
    && next_word[15:12] != TWO_WORD_PREFIX) |=>
    nop_cycle [*4] ##1 !nop_cycle)
    else $error("one-word skip not one nop");
  // Discarded slots must never touch data memory
  a_nop_no_write: assert property (@(posedge clock) disable iff (rst)
    nop_cycle |-> !mem_we)
    else $error("write during no-op slot");
  a_skip_two_word: assert property (@(posedge clock) disable iff (rst)
    (q == BTO_Q4 && nop_left == 2'h0 && do_skip && !is_bov
    && next_word[15:12] == TWO_WORD_PREFIX) |=>
    nop_cycle [*8] ##1 !nop_cycle)
    else $error("two-word skip not two nops");
  // Main scenarios the bench is expected to reach
  c_invert: cover property (@(posedge clock) disable iff (rst)
    mem_we);
  c_bov_taken: cover property (@(posedge clock) disable iff (rst)
    q == BTO_Q4 && nop_left == 2'h0 && is_bov && overflow_flag);
  c_skip_two: cover property (@(posedge clock) disable iff (rst)
    nop_left == 2'h2);
  c_skip_one: cover property (@(posedge clock) disable iff (rst)
    q == BTO_Q4 && nop_left == 2'h0 && do_skip
    && next_word[15:12] != TWO_WORD_PREFIX);
  c_indexed: cover property (@(posedge clock) disable iff (rst)
    q == BTO_Q1 && nop_left == 2'h0 && !instr_word[8] && ext_enable
    && instr_word[7:0] <= INDEXED_LIMIT);
endmodule : bto_exec
`default_nettype wire

// *** test/test_bit_toggle_overflow_branch_exec.sv ***
// Self-checking bench for the bit-invert, overflow branch and skip executor
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module test_bit_toggle_overflow_branch_exec;
  import bto_pkg::*;
  logic clock, rst, overflow_flag, ext_enable, mem_we, nop_cycle, got_we;
  logic [15:0] instr_word, next_word;
  logic [3:0] bank_select_register;
  logic [11:0] index_base, mem_addr, got_addr;
  logic [7:0] mem_rdata, mem_wdata, got_wdata;
  logic [20:0] pc, pc0, got_dpc;
  logic [1:0] phase;
  int errors, num_checks, got_nops;
  bto_exec dut (.clock(clock), .rst(rst), .instr_word(instr_word),
    .next_word(next_word), .overflow_flag(overflow_flag),
    .ext_enable(ext_enable), .bank_select_register(bank_select_register),
    .index_base(index_base), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .pc(pc), .phase(phase),
    .nop_cycle(nop_cycle));
  // 50 MHz core clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic step();
    @(posedge clock);
    #1;
  endtask : step
  // Waits for a fresh Q1 slot, bounded so a stuck phase cannot hang us
  task automatic to_q1();
    int n;
    n = 0;
    while (!(phase === 2'h0 && nop_cycle === 1'b0) && n < 40) begin
      step();
      n++;
    end
    got_nops = n / 4;
  endtask : to_q1
  // One instruction: captures the Q4 write, then counts no-op cycles
  task automatic run(input logic [15:0] w, nw, input logic [7:0] rd,
      input int en, input logic [20:0] ed, input logic ew);
    to_q1();
    instr_word = w;
    next_word = nw;
    mem_rdata = rd;
    pc0 = pc;
    repeat (3) step();
    got_we = mem_we;
    got_addr = mem_addr;
    got_wdata = mem_wdata;
    step();
    to_q1();
    got_dpc = pc - pc0;
    `CHK("nops", en, got_nops)
    `CHK("dpc", ed, got_dpc)
    `CHK("we", ew, got_we)
  endtask : run
  task automatic inv(input logic [15:0] w, input logic [7:0] rd, d,
      input logic [11:0] a);
    run(w, 16'h0000, rd, 0, PC_STEP, 1'b1);
    `CHK("addr", a, got_addr)
    `CHK("wdata", d, got_wdata)
  endtask : inv
  task automatic t_invert();
    bank_select_register = 4'h3;
    inv(16'h7942, 8'h75, 8'h65, 12'h342);
    inv(16'h7042, 8'h00, 8'h01, 12'h042);
    inv(16'h7EA0, 8'hFF, 8'h7F, 12'hFA0);
  endtask : t_invert
  // Boundary of the indexed window on both sides
  task automatic t_indexed();
    ext_enable = 1'b1;
    index_base = 12'h100;
    inv(16'h725F, 8'h00, 8'h02, 12'h15F);
    inv(16'h7260, 8'h00, 8'h02, 12'hF60);
    inv(16'h735F, 8'h00, 8'h02, 12'h35F);
  endtask : t_indexed
  // Extreme offsets, flag clear, and a neighbour opcode
  task automatic t_branch();
    overflow_flag = 1'b1;
    run(16'hE480, 16'h0, 8'h0, 1, 21'h1FFF02, 1'b0);
    run(16'hE47F, 16'h0, 8'h0, 1, 21'h000100, 1'b0);
    run(16'hE005, 16'h0, 8'h0, 0, PC_STEP, 1'b0);
    overflow_flag = 1'b0;
    run(16'hE405, 16'h0, 8'h0, 0, PC_STEP, 1'b0);
  endtask : t_branch
  task automatic t_skip();
    run(16'hB710, 16'h0000, 8'hF7, 1, 21'h4, 1'b0);
    run(16'hB710, 16'h0000, 8'h08, 0, 21'h2, 1'b0);
    run(16'hB710, 16'hF000, 8'hF7, 2, 21'h6, 1'b0);
    run(16'hA710, 16'hF000, 8'h08, 2, 21'h6, 1'b0);
    run(16'hA710, 16'h0000, 8'hF7, 0, 21'h2, 1'b0);
  endtask : t_skip
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  // Main sequence after a 3-cycle reset
  initial begin
    rst = 1'b1;
    {instr_word, next_word, mem_rdata, index_base} = '0;
    {overflow_flag, ext_enable, bank_select_register} = '0;
    errors = 0;
    num_checks = 0;
    repeat (3) step();
    `CHK("rst pc", PC_RESET, pc)
    `CHK("rst we", 1'b0, mem_we)
    rst = 1'b0;
    t_invert();
    t_indexed();
    t_branch();
    t_skip();
    give_verdict();
  end
  // Run needs about 90 cycles; the 3000-cycle limit, over thirty times that, is a hang
  initial begin
    #60000;
    errors++;
    give_verdict();
  end
endmodule : test_bit_toggle_overflow_branch_exec
`default_nettype wire
